//--- pkg/integrity_pkg.sv
// Constants and register layout for the system integrity monitor
package integrity_pkg;
  // ********************************************************
  // Register map
  // ********************************************************
  localparam logic [11:0] ADDR_CTRL_STATUS = 12'h000;
  localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_IRQ_MASK    = 12'h008;
  localparam logic [11:0] ADDR_OPTIONS     = 12'h00C;
  // Control/status bit positions
  localparam int BIT_SRC_SEL      = 7;
  localparam int BIT_VEV_IE       = 6;
  localparam int BIT_VEV_FLAG     = 5;
  localparam int BIT_LV_CAUSE     = 4;
  localparam int BIT_CF_IE        = 2;
  localparam int BIT_CF_DET       = 1;
  localparam int BIT_WDG_CAUSE    = 0;
  // Interrupt status / mask bit positions
  localparam int IRQ_VEV          = 0;
  localparam int IRQ_CF           = 1;
  // Options register bit positions
  localparam int OPT_LVD_EN       = 0;
  localparam int OPT_LVD_TH_LO    = 1;
  localparam int OPT_CSS_EN       = 3;
  localparam int OPT_PLL_EN       = 4;
  localparam int OPT_LONG_DELAY   = 5;
  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [1:0] IRQ_RESET     = 2'h0;
  localparam logic [5:0] OPT_RESET     = 6'h01;
  // ********************************************************
  // Reset delay counts, in cpu clock cycles
  // ********************************************************
  localparam logic [12:0] DELAY_SHORT  = 13'h0100;
  localparam logic [12:0] DELAY_LONG   = 13'h1000;
  // Threshold encodings
  typedef enum logic [1:0] {
    TH_LOW  = 2'b00,
    TH_MED  = 2'b01,
    TH_HIGH = 2'b11
  } threshold_e;
endpackage

//--- logic/sync2.sv
// Two-flop level synchroniser
`timescale 1ns/1ns
module sync2 (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

//--- logic/system_integrity_monitor.sv
// System integrity monitor: supply detectors, clock security, APB registers
`timescale 1ns/1ns
module system_integrity_monitor
  import integrity_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        supply_low_raw,
  input  wire logic        supply_cmp_raw,
  input  wire logic        sense_cmp_raw,
  input  wire logic        main_clock_lost_raw,
  input  wire logic        main_clock_glitch,
  input  wire logic        watchdog_reset,
  input  wire logic        cpu_global_mask,
  input  wire logic        voltage_irq_ack,
  input  wire logic        halt_mode,
  output logic             reset_pin_n,
  output logic             reset_pin_oe,
  output logic             core_reset_n,
  output logic             use_safe_oscillator,
  output logic             glitch_blank,
  output logic             voltage_irq,
  output logic             clock_fail_irq,
  output logic             irq,
  output logic             wake_request,
  output logic      [1:0]  threshold_sel
);
  import integrity_pkg::*;

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic [5:0]  opts;
    logic        vflag_prev;
    logic        ie_prev;
    logic [12:0] delay_cnt;
    logic        in_delay;
    logic        lv_reset_seen;
    logic        vev_pending;
    logic        cf_pending;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        reset_pin_oe;
    logic        core_reset_n;
    logic        safe_osc;
    logic        glitch_blank;
    logic        voltage_irq;
    logic        clock_fail_irq;
    logic        irq;
    logic        wake;
  } state_s;

  state_s s_q;
  state_s s_d;

  logic supply_low;
  logic supply_cmp;
  logic sense_cmp;
  logic clock_lost;

  // ********************************************************
  // Synchronisers
  // ********************************************************
  sync2 u_sync_low  (.pclk(pclk), .presetn(presetn), .din(supply_low_raw),  .dout(supply_low));
  sync2 u_sync_sup  (.pclk(pclk), .presetn(presetn), .din(supply_cmp_raw),  .dout(supply_cmp));
  sync2 u_sync_sns  (.pclk(pclk), .presetn(presetn), .din(sense_cmp_raw),   .dout(sense_cmp));
  sync2 u_sync_clk  (.pclk(pclk), .presetn(presetn), .din(main_clock_lost_raw), .dout(clock_lost));

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction

  logic lvd_en;
  logic css_en;
  logic cmp_sel;
  logic vflag;
  logic acc;
  logic wr;
  logic rd;

  always_comb begin
    lvd_en  = s_q.opts[OPT_LVD_EN];
    css_en  = s_q.opts[OPT_CSS_EN];
    cmp_sel = s_q.ctrl[BIT_SRC_SEL] ? sense_cmp : supply_cmp;
    vflag   = lvd_en & cmp_sel;
    acc     = psel & penable & ~s_q.pready;
    wr      = acc & pwrite;
    rd      = acc & ~pwrite;
  end

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    s_d = s_q;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    // Low supply: hold core and pin in reset, restart delay
    if (lvd_en && supply_low) begin
      s_d.reset_pin_oe  = 1'b1;
      s_d.core_reset_n  = 1'b0;
      s_d.in_delay      = 1'b1;
      s_d.lv_reset_seen = 1'b1;
      s_d.delay_cnt = s_q.opts[OPT_LONG_DELAY] ? DELAY_LONG : DELAY_SHORT;
    end else if (s_q.in_delay) begin
      // Pin stays low through the delay phase
      if (s_q.delay_cnt == 13'h0001) begin
        s_d.in_delay     = 1'b0;
        s_d.reset_pin_oe = 1'b0;
        s_d.core_reset_n = 1'b1;
      end
      s_d.delay_cnt = s_q.delay_cnt - 13'h0001;
    end
    // Core reset by the detector reinitialises ctrl and irq status; low-voltage cause kept, watchdog cause cleared
    if (!s_q.core_reset_n) begin
      s_d.ctrl = CTRL_RESET;
      s_d.irq_status = IRQ_RESET;
      s_d.vev_pending = 1'b0;
      s_d.ctrl[BIT_LV_CAUSE] = s_q.lv_reset_seen | s_q.ctrl[BIT_LV_CAUSE];
      s_d.ctrl[BIT_WDG_CAUSE] = 1'b0;
    end
    s_d.lv_reset_seen = s_d.lv_reset_seen & ~s_q.core_reset_n;
    if (watchdog_reset) begin
      s_d.ctrl[BIT_WDG_CAUSE] = 1'b1;
    end
    // Halt blocks register writes and clock security; safe oscillator forced off
    if (!halt_mode && s_q.core_reset_n) begin
      if (wr) begin
        if (hit(paddr, ADDR_CTRL_STATUS)) begin
          s_d.ctrl[BIT_SRC_SEL] = pwdata[BIT_SRC_SEL];
          s_d.ctrl[BIT_VEV_IE]  = pwdata[BIT_VEV_IE];
          s_d.ctrl[BIT_CF_IE]   = pwdata[BIT_CF_IE];
          if (!pwdata[BIT_LV_CAUSE]) s_d.ctrl[BIT_LV_CAUSE] = 1'b0;
          if (!pwdata[BIT_WDG_CAUSE] && !watchdog_reset) s_d.ctrl[BIT_WDG_CAUSE] = 1'b0;
        end else if (hit(paddr, ADDR_IRQ_STATUS)) begin
          s_d.irq_status = s_q.irq_status & ~pwdata[1:0];
        end else if (hit(paddr, ADDR_IRQ_MASK)) begin
          s_d.irq_mask = pwdata[1:0];
        end else if (hit(paddr, ADDR_OPTIONS)) begin
          s_d.opts = pwdata[5:0];
        end else begin
          s_d.pslverr = 1'b1;
        end
      end
      // Fail flag follows safe oscillator; read clears after recovery
      s_d.safe_osc = css_en & clock_lost;
      if (css_en && clock_lost) begin
        s_d.ctrl[BIT_CF_DET] = 1'b1;
      end else if (rd && hit(paddr, ADDR_CTRL_STATUS)) begin
        s_d.ctrl[BIT_CF_DET] = 1'b0;
      end
      if (!css_en) s_d.ctrl[BIT_CF_DET] = 1'b0;
      if (css_en && clock_lost && !s_q.safe_osc && s_q.ctrl[BIT_CF_IE]) begin
        s_d.cf_pending = 1'b1;
        s_d.irq_status[IRQ_CF] = 1'b1;
      end else if (!s_q.safe_osc) begin
        s_d.cf_pending = 1'b0;
      end
    end else if (halt_mode) begin
      s_d.safe_osc = 1'b0;
    end
    s_d.ctrl[BIT_VEV_FLAG] = vflag;
    // Voltage events: toggle, or enable while flag set
    s_d.vflag_prev = vflag;
    s_d.ie_prev = s_q.ctrl[BIT_VEV_IE];
    if (voltage_irq_ack) s_d.vev_pending = 1'b0;
    if (lvd_en && s_q.ctrl[BIT_VEV_IE] && s_q.core_reset_n && !s_q.in_delay) begin
      if ((vflag != s_q.vflag_prev) || (!s_q.ie_prev && vflag)) begin
        s_d.vev_pending = 1'b1;
        s_d.irq_status[IRQ_VEV] = 1'b1;
      end
    end
    if (!s_q.ctrl[BIT_VEV_IE]) s_d.vev_pending = 1'b0;
    // Glitch filter only with doubling loop
    s_d.glitch_blank = s_q.opts[OPT_PLL_EN] & main_clock_glitch;
    s_d.voltage_irq    = s_d.vev_pending & ~cpu_global_mask;
    s_d.clock_fail_irq = s_d.cf_pending & css_en & ~cpu_global_mask;
    s_d.wake = s_d.vev_pending | s_d.cf_pending;
    s_d.irq = |(s_d.irq_status & s_d.irq_mask);
    if (acc) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0000_0000;
      if (!pwrite) begin
        if (hit(paddr, ADDR_CTRL_STATUS)) s_d.prdata[7:0] = s_q.ctrl;
        else if (hit(paddr, ADDR_IRQ_STATUS)) s_d.prdata[1:0] = s_q.irq_status;
        else if (hit(paddr, ADDR_IRQ_MASK)) s_d.prdata[1:0] = s_q.irq_mask;
        else if (hit(paddr, ADDR_OPTIONS)) s_d.prdata[5:0] = s_q.opts;
        else s_d.pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.opts <= OPT_RESET;
      s_q.core_reset_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    prdata              = s_q.prdata;
    pready              = s_q.pready;
    pslverr             = s_q.pslverr;
    reset_pin_n         = 1'b0;
    reset_pin_oe        = s_q.reset_pin_oe;
    core_reset_n        = s_q.core_reset_n;
    use_safe_oscillator = s_q.safe_osc;
    glitch_blank        = s_q.glitch_blank;
    voltage_irq         = s_q.voltage_irq;
    clock_fail_irq      = s_q.clock_fail_irq;
    irq                 = s_q.irq;
    wake_request        = s_q.wake;
    threshold_sel       = s_q.opts[2:1];
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  sequence seq_low;
    lvd_en && supply_low;
  endsequence
  AST_LOW_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    seq_low |=> (reset_pin_oe && !core_reset_n)) else $error("no reset on low supply");
  AST_FLAG_MIRROR: assert property (@(posedge pclk) disable iff (!presetn)
    1 |=> s_q.ctrl[BIT_VEV_FLAG] == $past(vflag)) else $error("flag not mirrored");
  AST_NO_LVD: assert property (@(posedge pclk) disable iff (!presetn)
    !lvd_en |-> !vflag) else $error("aux active without detector");
  AST_ACK: assert property (@(posedge pclk) disable iff (!presetn)
    voltage_irq_ack && !s_q.ctrl[BIT_VEV_IE] |=> !s_q.vev_pending) else $error("pending kept");
  AST_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.in_delay && !s_q.vev_pending && !voltage_irq_ack |=> !s_q.vev_pending)
    else $error("irq during delay");
  AST_SAFE: assert property (@(posedge pclk) disable iff (!presetn)
    css_en && clock_lost && !halt_mode && s_q.core_reset_n |=> use_safe_oscillator)
    else $error("safe osc not used");
  AST_HALT: assert property (@(posedge pclk) disable iff (!presetn)
    halt_mode |=> !use_safe_oscillator) else $error("css active in halt");
  AST_MASK: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_global_mask |=> !voltage_irq && !clock_fail_irq) else $error("irq while masked");
  AST_GLITCH: assert property (@(posedge pclk) disable iff (!presetn)
    !s_q.opts[OPT_PLL_EN] |=> !glitch_blank) else $error("filter without pll");
endmodule

//--- verif/tb.sv
// Self-checking testbench for the system integrity monitor
`timescale 1ns/1ns
module tb;
  import integrity_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        sup_low, sup_cmp, sen_cmp, lost, glitch, wdg, gmask, ack, halt;
  logic        oe, core_n, safe, blank, virq, cirq, irq, e, wk, pin_n;
  logic [1:0]  th;
  int          errors, check_count, cyc;

  system_integrity_monitor dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supply_low_raw(sup_low),
    .supply_cmp_raw(sup_cmp), .sense_cmp_raw(sen_cmp), .main_clock_lost_raw(lost),
    .main_clock_glitch(glitch), .watchdog_reset(wdg), .cpu_global_mask(gmask),
    .voltage_irq_ack(ack), .halt_mode(halt), .reset_pin_n(pin_n), .reset_pin_oe(oe),
    .core_reset_n(core_n), .use_safe_oscillator(safe), .glitch_blank(blank),
    .voltage_irq(virq), .clock_fail_irq(cirq), .irq(irq), .wake_request(wk),
    .threshold_sel(th));

  // ********
  // Clock, timeout and bus tasks
  // ********
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Whole run is well under a thousand cycles; this ceiling only catches a hang
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      final_report();
    end
  end

  task automatic final_report();
    if (errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Holds the request until pready is sampled high, bounded wait
  task automatic apb(input logic wr_n, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr_n; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 50) chk("pready", 32'h0000_0001, 32'h0000_0000);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input string n, input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, x, r);
  endtask

  // ********
  // Test sequence
  // ********
  initial begin
    {presetn, psel, penable, pwrite, sup_low, sup_cmp, sen_cmp} = '0;
    {lost, glitch, wdg, gmask, ack, halt} = '0;
    paddr = '0; pwdata = '0; errors = 0; check_count = 0; cyc = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rc("ctrl reset", ADDR_CTRL_STATUS, 32'h0000_0000);
    rc("opt reset", ADDR_OPTIONS, 32'h0000_0001);
    chk("pin oe idle", 32'h0000_0000, {31'h0, oe});
    chk("pin level", 32'h0000_0000, {31'h0, pin_n});
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, e});
    chk("unmapped data", 32'h0000_0000, r);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) continue;
      wr(ADDR_OPTIONS, 32'(i * 2 + 1));
      w(2);
      chk("threshold", 32'(i), {30'h0, th});
    end
    wr(ADDR_OPTIONS, 32'h0000_0001);
    sup_cmp <= 1'b1;
    w(5);
    rc("flag supply", ADDR_CTRL_STATUS, 32'h0000_0020);
    // Writing the flag bit must not stick: it follows the comparator only
    wr(ADDR_CTRL_STATUS, 32'h0000_00a0);
    w(5);
    rc("flag sense", ADDR_CTRL_STATUS, 32'h0000_0080);
    wr(ADDR_IRQ_MASK, 32'h0000_0003);
    wr(ADDR_CTRL_STATUS, 32'h0000_00c0);
    sen_cmp <= 1'b1;
    w(5);
    chk("virq rise", 32'h0000_0001, {31'h0, virq});
    chk("irq out", 32'h0000_0001, {31'h0, irq});
    chk("wake on irq", 32'h0000_0001, {31'h0, wk});
    ack <= 1'b1;
    w(1);
    ack <= 1'b0;
    w(3);
    chk("virq ack", 32'h0000_0000, {31'h0, virq});
    chk("wake ack", 32'h0000_0000, {31'h0, wk});
    wr(ADDR_IRQ_STATUS, 32'h0000_0003);
    w(2);
    chk("irq w1c", 32'h0000_0000, {31'h0, irq});
    gmask <= 1'b1;
    sen_cmp <= 1'b0;
    w(5);
    chk("virq masked", 32'h0000_0000, {31'h0, virq});
    gmask <= 1'b0;
    w(3);
    chk("virq fall", 32'h0000_0001, {31'h0, virq});
    ack <= 1'b1;
    w(1);
    ack <= 1'b0;
    wr(ADDR_IRQ_STATUS, 32'h0000_0003);
    wr(ADDR_IRQ_MASK, 32'h0000_0000);
    wr(ADDR_CTRL_STATUS, 32'h0000_0080);
    sen_cmp <= 1'b1;
    w(5);
    chk("no irq ie off", 32'h0000_0000, {31'h0, virq});
    wr(ADDR_CTRL_STATUS, 32'h0000_00c0);
    w(3);
    chk("virq on enable", 32'h0000_0001, {31'h0, virq});
    chk("irq mask off", 32'h0000_0000, {31'h0, irq});
    wr(ADDR_IRQ_MASK, 32'h0000_0003);
    w(2);
    chk("irq mask on", 32'h0000_0001, {31'h0, irq});
    ack <= 1'b1;
    w(1);
    ack <= 1'b0;
    wr(ADDR_IRQ_STATUS, 32'h0000_0003);
    wr(ADDR_OPTIONS, 32'h0000_0000);
    sen_cmp <= 1'b0;
    sup_cmp <= 1'b0;
    w(5);
    chk("no irq lvd off", 32'h0000_0000, {31'h0, virq});
    wr(ADDR_OPTIONS, 32'h0000_0009);
    wr(ADDR_CTRL_STATUS, 32'h0000_0004);
    lost <= 1'b1;
    w(5);
    chk("safe osc", 32'h0000_0001, {31'h0, safe});
    chk("cf irq", 32'h0000_0001, {31'h0, cirq});
    rc("cf flag lost", ADDR_CTRL_STATUS, 32'h0000_0006);
    lost <= 1'b0;
    w(5);
    chk("safe back", 32'h0000_0000, {31'h0, safe});
    rc("cf flag read", ADDR_CTRL_STATUS, 32'h0000_0006);
    rc("cf flag clr", ADDR_CTRL_STATUS, 32'h0000_0004);
    wr(ADDR_OPTIONS, 32'h0000_0001);
    lost <= 1'b1;
    w(5);
    rc("cf css off", ADDR_CTRL_STATUS, 32'h0000_0004);
    glitch <= 1'b1;
    w(3);
    chk("blank pll off", 32'h0000_0000, {31'h0, blank});
    wr(ADDR_OPTIONS, 32'h0000_0019);
    w(3);
    chk("blank pll on", 32'h0000_0001, {31'h0, blank});
    glitch <= 1'b0;
    lost <= 1'b0;
    halt <= 1'b1;
    wr(ADDR_CTRL_STATUS, 32'h0000_0080);
    rc("halt frozen", ADDR_CTRL_STATUS, 32'h0000_0006);
    lost <= 1'b1;
    w(5);
    chk("halt no safe", 32'h0000_0000, {31'h0, safe});
    halt <= 1'b0;
    lost <= 1'b0;
    wdg <= 1'b1;
    w(1);
    wdg <= 1'b0;
    w(5);
    rc("wdg cause", ADDR_CTRL_STATUS, 32'h0000_0007);
    sup_low <= 1'b1;
    w(5);
    chk("pin driven", 32'h0000_0001, {31'h0, oe});
    chk("core held", 32'h0000_0000, {31'h0, core_n});
    sup_low <= 1'b0;
    w(240);
    chk("delay held", 32'h0000_0000, {31'h0, core_n});
    for (int k = 0; k < 200 && core_n !== 1'b1; k++) w(1);
    chk("core freed", 32'h0000_0001, {31'h0, core_n});
    chk("pin freed", 32'h0000_0000, {31'h0, oe});
    rc("lv cause", ADDR_CTRL_STATUS, 32'h0000_0010);
    wr(ADDR_CTRL_STATUS, 32'h0000_0000);
    rc("lv cause clr", ADDR_CTRL_STATUS, 32'h0000_0000);
    final_report();
  end
endmodule
